// file: pbs_device.sv
// Module end: power on/off sequencer driven by the power button line.
`timescale 1ns/1ps
`include "pbs_defs.svh"
// Functional notes
// [R1] Falling edge: on when off, delayed off.
// [R2] Controller holds line low 50 ms to switch on.
// [R3] Off delay zero blocks line switch-off; default.
// [R4] Nonzero off delay accepted only 100..1000 ms.
// [R5] Off pulse lasts at least delay, 5000 ms max.
// [R6] Software off command also switches off; ignored while booting.
// [R7] Controller only pulls low or releases line.
// [R8] Floating line held high enables RTC sleep.
// [R9] Line tied low: recover by reset/power cycle.
// [R10] Ready about 1.1 s after switch on.
// [R11] Controller quiets its I/O when shut down.
// [R12] Reset low suspends everything until released.
// [R13] Synchronise line; ignore edges mid-transition.
module pbs_device (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic set_dly_stb,
    input wire logic [10:0] set_dly_ms,
    input wire logic software_off_command,
    input wire logic rtc_sleep_req,
    output logic powered_on,
    output logic cmd_ready,
    output logic dly_rejected,
    output logic rtc_sleep,
    output logic [10:0] off_delay_setting,
    pbs_link_if.device link
);
    localparam logic [15:0] CYC_MS = 16'(`PBS_CYC_PER_MS);
    localparam logic [10:0] BOOT_MS = 11'(`PBS_BOOT_MS);
    localparam logic [10:0] SHUT_MS = 11'(`PBS_SHUTDOWN_MS);

    pbs_pkg::pbs_state_t state_r;
    logic sync1_r;
    logic sync2_r;
    logic line_prev_r;
    logic fall;
    logic tick;
    logic [15:0] sub_r;
    logic [10:0] ms_r;
    pbs_pkg::pbs_state_t state_nxt;
    logic restart;
    logic dly_legal;
    logic boot_done;
    logic hold_done;
    logic shut_done;

    // ********************************************************
    // Line synchroniser and falling edge.
    // ********************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            line_prev_r <= 1'b1;
        end else if (clk_en) begin
            sync1_r <= link.line_i; // [R13]
            sync2_r <= sync1_r;
            line_prev_r <= sync2_r;
        end
    end

    assign fall = line_prev_r && !sync2_r; // [R1]

    // ********************************************************
    // Off delay setting.
    // ********************************************************
    // Zero is legal as well: it turns switch-off by the line back off.
    assign dly_legal = (set_dly_ms == 11'h000) ||
                       (set_dly_ms >= 11'(`PBS_OFF_DLY_MIN_MS) &&
                        set_dly_ms <= 11'(`PBS_OFF_DLY_MAX_MS)); // [R4]

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            off_delay_setting <= `PBS_OFF_DLY_RESET; // [R3]
        end else if (clk_en && set_dly_stb && dly_legal) begin
            off_delay_setting <= set_dly_ms; // [R4]
        end
    end

    // Refusal is a one-cycle pulse; the stored value is left untouched.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dly_rejected <= 1'b0;
        end else if (clk_en) begin
            dly_rejected <= set_dly_stb && !dly_legal; // [R4]
        end
    end

    // ********************************************************
    // Millisecond timebase, restarted on every state change.
    // ********************************************************
    assign tick = (sub_r == CYC_MS - 16'h0001);
    assign restart = (state_nxt != state_r);

    // Both counters restart on every change of state, so each wait is
    // measured from the cycle that entered its state.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sub_r <= 16'h0000;
        end else if (clk_en) begin
            if (restart || tick) begin
                sub_r <= 16'h0000;
            end else begin
                sub_r <= sub_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ms_r <= 11'h000;
        end else if (clk_en) begin
            if (restart) begin
                ms_r <= 11'h000;
            end else if (tick) begin
                ms_r <= ms_r + 11'h001;
            end
        end
    end

    assign boot_done = tick && (ms_r + 11'h001 >= BOOT_MS); // [R10]
    assign hold_done = tick && (ms_r + 11'h001 >= off_delay_setting);
    assign shut_done = tick && (ms_r + 11'h001 >= SHUT_MS);

    // ********************************************************
    // Power sequencer.
    // ********************************************************
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pbs_pkg::PBS_OFF: begin
                if (fall) begin
                    state_nxt = pbs_pkg::PBS_BOOTING; // [R1]
                end
            end
            pbs_pkg::PBS_BOOTING: begin
                // Edges here are ignored until boot finishes.
                if (boot_done) begin
                    state_nxt = pbs_pkg::PBS_ON; // [R10] [R13]
                end
            end
            pbs_pkg::PBS_ON: begin
                if (software_off_command) begin
                    state_nxt = pbs_pkg::PBS_SHUTTING; // [R6]
                end else if (fall && off_delay_setting != 11'h000) begin
                    state_nxt = pbs_pkg::PBS_OFF_WAIT; // [R3]
                end
            end
            pbs_pkg::PBS_OFF_WAIT: begin
                // Releasing early cancels; the pulse must span the delay.
                if (software_off_command) begin
                    state_nxt = pbs_pkg::PBS_SHUTTING; // [R6]
                end else if (sync2_r) begin
                    state_nxt = pbs_pkg::PBS_ON; // [R5]
                end else if (hold_done) begin
                    state_nxt = pbs_pkg::PBS_SHUTTING; // [R1]
                end
            end
            pbs_pkg::PBS_SHUTTING: begin
                if (shut_done) begin
                    state_nxt = pbs_pkg::PBS_OFF; // [R13]
                end
            end
            default: begin
                state_nxt = pbs_pkg::PBS_OFF;
            end
        endcase
    end

    // ********************************************************
    // State register.
    // ********************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= pbs_pkg::PBS_OFF; // [R12]
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // ********************************************************
    // Registered status outputs.
    // ********************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            powered_on <= 1'b0;
            cmd_ready <= 1'b0;
            rtc_sleep <= 1'b0;
        end else if (clk_en) begin
            powered_on <= state_r != pbs_pkg::PBS_OFF;
            cmd_ready <= state_r == pbs_pkg::PBS_ON ||
                         state_r == pbs_pkg::PBS_OFF_WAIT; // [R10]
            // A low line wakes the module, so sleep holds only while high.
            rtc_sleep <= rtc_sleep_req && sync2_r &&
                         state_r == pbs_pkg::PBS_OFF; // [R8]
        end
    end
endmodule : pbs_device

// file: pbs_defs.svh
// Timing and setting constants for the power button sequencer.
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH

`define PBS_CLK_HZ 40000000
`define PBS_CYC_PER_MS (`PBS_CLK_HZ / 1000)
`define PBS_ON_PULSE_MS 50
`define PBS_OFF_MAX_MS 5000
`define PBS_BOOT_MS 1100
`define PBS_OFF_DLY_MIN_MS 100
`define PBS_OFF_DLY_MAX_MS 1000
`define PBS_OFF_DLY_RESET 11'h000
`define PBS_SHUTDOWN_MS 10

`endif

// file: pbs_pkg.sv
// Types shared by both ends of the power button link.
package pbs_pkg;
    typedef enum logic [2:0] {
        PBS_OFF = 3'b000,
        PBS_BOOTING = 3'b001,
        PBS_ON = 3'b010,
        PBS_OFF_WAIT = 3'b011,
        PBS_SHUTTING = 3'b100
    } pbs_state_t;

    typedef enum logic [1:0] {
        PBS_H_IDLE = 2'b00,
        PBS_H_PULL = 2'b01,
        PBS_H_GAP = 2'b10
    } pbs_hstate_t;
endpackage : pbs_pkg

// file: pbs_link_if.sv
// Open-drain power button line joining the controller and the module.
`timescale 1ns/1ps
interface pbs_link_if;
    logic line_o;
    logic line_oe;
    logic line_i;

    // Only pull-low is possible; the module's internal pull-up wins otherwise.
    assign line_i = (line_oe && !line_o) ? 1'b0 : 1'b1;

    modport device (
        input line_i
    );
    modport ctrl (
        output line_o,
        output line_oe
    );
endinterface : pbs_link_if

// file: pbs_ctrl.sv
// Controlling end: pulls the power button line low for timed pulses.
`timescale 1ns/1ps
`include "pbs_defs.svh"
module pbs_ctrl (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic press_req,
    input wire logic [12:0] press_ms,
    output logic busy,
    output logic io_quiet,
    input wire logic shutdown_long,
    pbs_link_if.ctrl link
);
    localparam logic [15:0] CYC_MS = 16'(`PBS_CYC_PER_MS);

    pbs_pkg::pbs_hstate_t state_r;
    logic [15:0] sub_r;
    logic [12:0] ms_r;
    logic [12:0] len_r;
    logic pull_r;

    // A zero or over-long request is widened or clipped to the legal span.
    function automatic logic [12:0] clamp_len(input logic [12:0] v);
        if (v < 13'(`PBS_ON_PULSE_MS)) begin
            return 13'(`PBS_ON_PULSE_MS);
        end
        if (v > 13'(`PBS_OFF_MAX_MS)) begin
            return 13'(`PBS_OFF_MAX_MS);
        end
        return v;
    endfunction : clamp_len

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= pbs_pkg::PBS_H_IDLE;
            sub_r <= 16'h0000;
            ms_r <= 13'h0000;
            len_r <= 13'h0000;
            pull_r <= 1'b0;
        end else if (clk_en) begin
            unique case (state_r)
                pbs_pkg::PBS_H_IDLE: begin
                    sub_r <= 16'h0000;
                    ms_r <= 13'h0000;
                    if (press_req) begin
                        len_r <= clamp_len(press_ms); // [R2] [R5]
                        pull_r <= 1'b1; // [R7]
                        state_r <= pbs_pkg::PBS_H_PULL;
                    end
                end
                pbs_pkg::PBS_H_PULL: begin
                    if (sub_r == CYC_MS - 16'h0001) begin
                        sub_r <= 16'h0000;
                        ms_r <= ms_r + 13'h0001;
                        if (ms_r + 13'h0001 >= len_r) begin
                            pull_r <= 1'b0; // [R7]
                            state_r <= pbs_pkg::PBS_H_GAP;
                        end
                    end else begin
                        sub_r <= sub_r + 16'h0001;
                    end
                end
                pbs_pkg::PBS_H_GAP: begin
                    // One released millisecond lets the module see high again.
                    if (sub_r == CYC_MS - 16'h0001) begin
                        sub_r <= 16'h0000;
                        state_r <= pbs_pkg::PBS_H_IDLE;
                    end else begin
                        sub_r <= sub_r + 16'h0001;
                    end
                end
                default: begin
                    state_r <= pbs_pkg::PBS_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            io_quiet <= 1'b0;
        end else if (clk_en) begin
            busy <= (state_r != pbs_pkg::PBS_H_IDLE) || press_req;
            io_quiet <= shutdown_long; // [R11]
        end
    end

    // Line is never driven high: output value is low, enable pulls it.
    assign link.line_o = 1'b0; // [R7] [R8] [R9]
    assign link.line_oe = pull_r;
endmodule : pbs_ctrl

// file: pbs_monitor.sv
// Concurrent checks on the power button link and the module status.
`timescale 1ns/1ps
module pbs_monitor (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic line_o,
    input wire logic line_oe,
    input wire logic line_i,
    input wire logic set_dly_stb,
    input wire logic [10:0] set_dly_ms,
    input wire logic software_off_command,
    input wire logic powered_on,
    input wire logic cmd_ready,
    input wire logic dly_rejected,
    input wire logic rtc_sleep,
    input wire logic [10:0] off_delay_setting,
    input wire logic shutdown_long,
    input wire logic io_quiet
);
    // ************
    // Boot counter
    // ************
    // Saturates, so a module left on for hours never wraps into a false
    // early-ready report.
    logic [25:0] on_cnt_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            on_cnt_r <= 26'h0000000;
        end else if (!powered_on) begin
            on_cnt_r <= 26'h0000000;
        end else if (on_cnt_r != 26'h3FFFFFF) begin
            on_cnt_r <= on_cnt_r + 26'h0000001;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    a_drive_only_low: assert property (line_oe |-> !line_o)
        else $error("Power line driven high.");
    a_power_on_edge: assert property ($fell(line_i) && !powered_on
        |-> ##[2:8] powered_on) else $error("Falling edge did not power on.");
    a_rtc_line_low: assert property ((!line_i) [*5] |-> !rtc_sleep)
        else $error("Sleep held with the line low.");
    a_delay_reject: assert property (
        set_dly_stb && set_dly_ms != 11'h000
        && (set_dly_ms < 11'h064 || set_dly_ms > 11'h3E8)
        |=> dly_rejected && $stable(off_delay_setting))
        else $error("Illegal delay not refused.");
    a_delay_accept: assert property (
        set_dly_stb && (set_dly_ms == 11'h000
        || (set_dly_ms >= 11'h064 && set_dly_ms <= 11'h3E8))
        |=> !dly_rejected && off_delay_setting == $past(set_dly_ms))
        else $error("Legal delay not stored.");
    a_reset_quiet: assert property (disable iff (1'h0) !rstn
        |-> !powered_on && !cmd_ready && off_delay_setting == 11'h000)
        else $error("Outputs active in reset.");
    a_boot_time_held: assert property ($rose(cmd_ready)
        |-> on_cnt_r >= 26'h29F62F8) else $error("Ready before boot time.");
    a_boot_edge_ignored: assert property ($fell(line_i) && powered_on
        && !cmd_ready && on_cnt_r < 26'h1000000 |-> powered_on [*8])
        else $error("Edge during boot changed state.");
    // Ready is a registered copy of the state, so it drops one edge after
    // the state has left the on states.
    a_soft_off_taken: assert property (
        cmd_ready && software_off_command
        |-> ##2 !cmd_ready) else $error("Software off not taken.");
    a_io_quiet_follow: assert property (
        ##1 io_quiet == $past(shutdown_long))
        else $error("Quiet output lags.");
    c_power_on: cover property ($rose(powered_on));
    c_reject: cover property (dly_rejected);
    c_sleep: cover property (rtc_sleep);
endmodule : pbs_monitor

// file: tb_power_button_on_off_sequencer.sv
// Testbench driving both ends of the power button link.
`timescale 1ns/1ps
module tb_power_button_on_off_sequencer;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic ctrl_rstn = 1'h0;
    logic set_dly_stb = 1'h0;
    logic [10:0] set_dly_ms = 11'h000;
    logic software_off_command = 1'h0;
    logic rtc_sleep_req = 1'h0;
    logic press_req = 1'h0;
    logic [12:0] press_ms = 13'h0032;
    logic shutdown_long = 1'h0;
    logic powered_on, cmd_ready, dly_rejected, rtc_sleep, busy, io_quiet;
    logic [10:0] off_delay_setting;
    logic [10:0] dly_val [6] = '{11'h064, 11'h063, 11'h3E8, 11'h3E9, 11'h7FF,
        11'h000};
    logic [10:0] dly_keep [6] = '{11'h064, 11'h064, 11'h3E8, 11'h3E8, 11'h3E8,
        11'h000};
    logic dly_rej [6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    pbs_link_if link ();
    pbs_device pbs_device_inst (.core_clk, .rstn, .clk_en(1'h1), .set_dly_stb,
        .set_dly_ms, .software_off_command, .rtc_sleep_req, .powered_on,
        .cmd_ready, .dly_rejected, .rtc_sleep, .off_delay_setting, .link);
    pbs_ctrl pbs_ctrl_inst (.core_clk, .rstn(ctrl_rstn), .clk_en(1'h1),
        .press_req, .press_ms, .busy, .io_quiet, .shutdown_long, .link);
    pbs_monitor pbs_monitor_inst (.core_clk, .rstn, .line_o(link.line_o),
        .line_oe(link.line_oe), .line_i(link.line_i), .set_dly_stb,
        .set_dly_ms, .software_off_command, .powered_on, .cmd_ready,
        .dly_rejected, .rtc_sleep, .off_delay_setting, .shutdown_long,
        .io_quiet);
    always #12.5 core_clk = ~core_clk;
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic write_delay(input logic [10:0] ms, input logic [10:0] kept,
                               input logic rej);
        @(negedge core_clk);
        set_dly_ms = ms;
        set_dly_stb = 1'h1;
        @(negedge core_clk);
        set_dly_stb = 1'h0;
        check(dly_rejected, rej);
        check(off_delay_setting, kept);
        @(negedge core_clk);
        check(dly_rejected, 1'h0);
    endtask : write_delay
    // ***************
    // Timed line pull
    // ***************
    // The shortest legal pull lasts millions of cycles, so scenarios cut it
    // short by resetting the controller end, or both ends at the final reset.
    task automatic press();
        @(negedge core_clk);
        press_req = 1'h1;
        @(negedge core_clk);
        press_req = 1'h0;
        repeat (10) @(negedge core_clk);
    endtask : press
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        check(powered_on, 1'h0);
        check(off_delay_setting, 11'h000);
        @(negedge core_clk);
        rstn = 1'h1;
        ctrl_rstn = 1'h1;
        rtc_sleep_req = 1'h1;
        repeat (6) @(negedge core_clk);
        check(rtc_sleep, 1'h1);
        check(off_delay_setting, 11'h000);
        foreach (dly_val[i]) begin
            write_delay(dly_val[i], dly_keep[i], dly_rej[i]);
        end
        press();
        check(link.line_i, 1'h0);
        check(busy, 1'h1);
        check(powered_on, 1'h1);
        check(rtc_sleep, 1'h0);
        check(cmd_ready, 1'h0);
        @(negedge core_clk);
        ctrl_rstn = 1'h0;
        @(negedge core_clk);
        ctrl_rstn = 1'h1;
        check(link.line_i, 1'h1);
        press();
        software_off_command = 1'h1;
        @(negedge core_clk);
        software_off_command = 1'h0;
        repeat (20) @(negedge core_clk);
        check(powered_on, 1'h1);
        check(cmd_ready, 1'h0);
        shutdown_long = 1'h1;
        @(negedge core_clk);
        check(io_quiet, 1'h1);
        shutdown_long = 1'h0;
        @(negedge core_clk);
        check(io_quiet, 1'h0);
        rstn = 1'h0;
        ctrl_rstn = 1'h0;
        #1;
        check(powered_on, 1'h0);
        @(negedge core_clk);
        rstn = 1'h1;
        ctrl_rstn = 1'h1;
        repeat (10) @(negedge core_clk);
        check(powered_on, 1'h0);
        check(rtc_sleep, 1'h1);
        end_of_test();
    end
endmodule : tb_power_button_on_off_sequencer
